// ---- hdl/btcr_defines.svh ----
// Constants for the third step-down channel control register bank
// Behaviour
// [R1] Standby code, offset 30h bits 5:0, writable
// [R2] Normal code, offset 33h bits 5:0, writable
// [R3] Bit 2 at 32h: zero masks fault
// [R4] 31h and 32h bits 7:3 read-only
// [R5] Bit 6 at 33h selects high range
// [R6] Host checks range before changing span select
// [R7] Codes map to 25mV or 50mV steps
// [R8] Code zero selects external feedback adjustable mode
// [R9] Codes written over bus are applied
// [R10] Enabled only with pin high and bit
// [R11] Power-good bit follows output threshold comparator
// [R12] Bank pin low normal, high standby code
// [R13] Reset values parameters; both codes equal default
`ifndef BTCR_DEFINES_SVH
`define BTCR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define BTCR_OFF_STANDBY   8'h30
`define BTCR_OFF_SPARE     8'h31
`define BTCR_OFF_CTRL      8'h32
`define BTCR_OFF_NORMAL    8'h33

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BTCR_CODE_MSB      5
`define BTCR_CODE_LSB      0
`define BTCR_BIT_ENABLE    0
`define BTCR_BIT_PGOOD     1
`define BTCR_BIT_UNMASK    2
`define BTCR_BIT_SPAN      6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BTCR_RST_CODE      6'h18
`define BTCR_RST_SPAN      1'b0
`define BTCR_RST_ENABLE    1'b0
`define BTCR_RST_UNMASK    1'b1
`define BTCR_RO_FILL       8'h00

// ----------------------------------------------------------------------------
// Voltage table, millivolts
// ----------------------------------------------------------------------------
`define BTCR_LOW_BASE_MV   13'h0271
`define BTCR_LOW_STEP_MV   13'h0019
`define BTCR_LOW_MIN_MV    13'h0320
`define BTCR_HIGH_BASE_MV  13'h04e2
`define BTCR_HIGH_STEP_MV  13'h0032
`define BTCR_ZERO_MV       13'h0000

`endif

// ---- hdl/btcr_pkg.sv ----
// Types shared by the third step-down channel register bank
package btcr_pkg;
   typedef logic [5:0]  btcr_code_t;
   typedef logic [7:0]  btcr_byte_t;
   typedef logic [12:0] btcr_mv_t;
endpackage

// ---- hdl/btcr_sync.sv ----
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`include "btcr_defines.svh"
module btcr_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // Levels
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   import btcr_pkg::*;

   logic [WIDTH-1:0] stageOne_q;
   logic [WIDTH-1:0] stageOne_d;
   logic [WIDTH-1:0] stageTwo_q;
   logic [WIDTH-1:0] stageTwo_d;

   // First stage feeds only the second stage
   always_comb begin
      stageOne_d = asyncIn;
      stageTwo_d = stageOne_q;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         stageOne_q <= '0;
         stageTwo_q <= '0;
      end else begin
         stageOne_q <= stageOne_d;
         stageTwo_q <= stageTwo_d;
      end
   end

   assign syncOut = stageTwo_q;
endmodule

// ---- hdl/btcr_vdecode.sv ----
// Voltage code to millivolt decoder for both output ranges
`timescale 1ns/1ps
`include "btcr_defines.svh"
module btcr_vdecode (
   // Selected setting
   input  wire logic               spanHigh,
   input  wire btcr_pkg::btcr_code_t code,
   // Decoded target
   output btcr_pkg::btcr_mv_t      millivolts,
   output logic                    adjustable
);
   import btcr_pkg::*;

   function automatic btcr_mv_t decodeMv(input logic high, input btcr_code_t n);
      btcr_mv_t raw;
      raw = '0;
      if (n == '0) begin
         raw = `BTCR_ZERO_MV;                                           // [R8]
      end else if (high) begin
         raw = 13'(`BTCR_HIGH_BASE_MV + 13'(n) * `BTCR_HIGH_STEP_MV);   // [R7]
      end else begin
         raw = 13'(`BTCR_LOW_BASE_MV + 13'(n) * `BTCR_LOW_STEP_MV);     // [R7]
         // Low table floors at its minimum for codes 1 to 6
         if (raw < `BTCR_LOW_MIN_MV) begin
            raw = `BTCR_LOW_MIN_MV;                                     // [R7]
         end
      end
      return raw;
   endfunction

   always_comb begin
      millivolts = decodeMv(spanHigh, code);
      adjustable = (code == '0);                                        // [R8]
   end
endmodule

// ---- hdl/btcr_top.sv ----
// Control and status register bank of the third step-down channel
`timescale 1ns/1ps
`include "btcr_defines.svh"
module btcr_top #(
   parameter btcr_pkg::btcr_code_t RST_NORMAL_CODE  = `BTCR_RST_CODE,
   parameter btcr_pkg::btcr_code_t RST_STANDBY_CODE = `BTCR_RST_CODE,
   parameter logic                 RST_SPAN         = `BTCR_RST_SPAN,
   parameter logic                 RST_ENABLE       = `BTCR_RST_ENABLE,
   parameter logic                 RST_UNMASK       = `BTCR_RST_UNMASK,
   parameter btcr_pkg::btcr_byte_t RO_FILL          = `BTCR_RO_FILL
) (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst,
   // Register port from the serial bus interface
   input  wire btcr_pkg::btcr_byte_t regAddr,
   input  wire btcr_pkg::btcr_byte_t regWrData,
   input  wire logic                 regWrEn,
   input  wire logic                 regRdEn,
   output btcr_pkg::btcr_byte_t      regRdData,
   output logic                      regRdValid,
   output logic                      regRdMiss,
   // Pins and analog status
   input  wire logic                 channelEnablePin,
   input  wire logic                 voltageBankPin,
   input  wire logic                 powerGoodIn,
   input  wire logic                 voltageFaultIn,
   // Converter control
   output logic                      channelEnable,
   output btcr_pkg::btcr_code_t      activeCode,
   output logic                      spanHigh,
   output logic                      adjustableMode,
   output btcr_pkg::btcr_mv_t        targetMillivolts,
   output logic                      targetChanged,
   output logic                      voltageFault
);
   import btcr_pkg::*;

   // -------------------------------------------------------------------------
   // Field helpers
   // -------------------------------------------------------------------------
   // Six-bit voltage code held in the low bits of a written byte
   function automatic btcr_code_t codeField(input btcr_byte_t value);
      return value[`BTCR_CODE_MSB:`BTCR_CODE_LSB];
   endfunction

   // Exact offset match; the bank answers to four offsets only
   function automatic logic offsetHit(input btcr_byte_t addr, input btcr_byte_t offset);
      return (addr == offset);
   endfunction

   // Read byte of a code register: fill on top, span or fill at bit 6, code below
   function automatic btcr_byte_t codeRead(input logic bitSix, input btcr_code_t value);
      return {RO_FILL[7], bitSix, value};
   endfunction

   // -------------------------------------------------------------------------
   // Pin synchronisation
   // -------------------------------------------------------------------------
   logic [3:0] pinSync;
   logic       enablePinSync;
   logic       bankPinSync;
   logic       powerGoodSync;
   logic       faultSync;

   btcr_sync #(
      .WIDTH (4)
   ) u_sync (
      .clock   (clock),
      .rst     (rst),
      .asyncIn ({voltageFaultIn, powerGoodIn, voltageBankPin, channelEnablePin}),
      .syncOut (pinSync)
   );

   assign enablePinSync = pinSync[0];
   assign bankPinSync   = pinSync[1];
   assign powerGoodSync = pinSync[2];
   assign faultSync     = pinSync[3];

   // -------------------------------------------------------------------------
   // Register decode
   // -------------------------------------------------------------------------
   logic       hitStandby;
   logic       hitSpare;
   logic       hitCtrl;
   logic       hitNormal;
   logic       wrStandby;
   logic       wrCtrl;
   logic       wrNormal;

   always_comb begin
      hitStandby = offsetHit(regAddr, `BTCR_OFF_STANDBY);
      hitSpare   = offsetHit(regAddr, `BTCR_OFF_SPARE);
      hitCtrl    = offsetHit(regAddr, `BTCR_OFF_CTRL);
      hitNormal  = offsetHit(regAddr, `BTCR_OFF_NORMAL);
   end

   // The spare offset and unmapped offsets get no strobe, so writes there are dropped
   always_comb begin
      wrStandby = regWrEn & hitStandby;
      wrCtrl    = regWrEn & hitCtrl;
      wrNormal  = regWrEn & hitNormal;
   end

   // -------------------------------------------------------------------------
   // Voltage codes and span
   // -------------------------------------------------------------------------
   btcr_code_t standbyCode_q;
   btcr_code_t standbyCode_d;
   btcr_code_t normalCode_q;
   btcr_code_t normalCode_d;
   logic       span_q;
   logic       span_d;

   // Read-only bits of a written byte are ignored
   always_comb begin
      standbyCode_d = standbyCode_q;
      normalCode_d  = normalCode_q;
      span_d        = span_q;
      if (wrStandby) begin
         standbyCode_d = codeField(regWrData);                       // [R1] [R9]
      end
      if (wrNormal) begin
         normalCode_d = codeField(regWrData);                        // [R2] [R9]
         span_d       = regWrData[`BTCR_BIT_SPAN];                   // [R5]
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         standbyCode_q <= RST_STANDBY_CODE;                          // [R13]
         normalCode_q  <= RST_NORMAL_CODE;                           // [R13]
         span_q        <= RST_SPAN;                                  // [R13]
      end else begin
         standbyCode_q <= standbyCode_d;
         normalCode_q  <= normalCode_d;
         span_q        <= span_d;
      end
   end

   // -------------------------------------------------------------------------
   // Enable and fault unmask bits
   // -------------------------------------------------------------------------
   logic       enableBit_q;
   logic       enableBit_d;
   logic       unmask_q;
   logic       unmask_d;

   always_comb begin
      enableBit_d = enableBit_q;
      unmask_d    = unmask_q;
      if (wrCtrl) begin
         enableBit_d = regWrData[`BTCR_BIT_ENABLE];                  // [R10]
         unmask_d    = regWrData[`BTCR_BIT_UNMASK];                  // [R3]
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         enableBit_q <= RST_ENABLE;                                  // [R13]
         unmask_q    <= RST_UNMASK;                                  // [R13]
      end else begin
         enableBit_q <= enableBit_d;
         unmask_q    <= unmask_d;
      end
   end

   // -------------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------------
   btcr_byte_t rdData_q;
   btcr_byte_t rdData_d;
   logic       rdValid_q;
   logic       rdValid_d;
   logic       rdMiss_q;
   logic       rdMiss_d;
   btcr_byte_t ctrlRead;

   // Read-only bits carry a fixed fill; software must not rely on them
   always_comb begin
      ctrlRead                   = RO_FILL;                          // [R4]
      ctrlRead[`BTCR_BIT_ENABLE] = enableBit_q;
      ctrlRead[`BTCR_BIT_PGOOD]  = powerGoodSync;                    // [R11]
      ctrlRead[`BTCR_BIT_UNMASK] = unmask_q;
   end

   always_comb begin
      rdData_d  = rdData_q;
      rdValid_d = regRdEn;
      rdMiss_d  = 1'b0;
      if (regRdEn) begin
         rdData_d = '0;
         if (hitStandby) begin
            rdData_d = codeRead(RO_FILL[6], standbyCode_q);          // [R1]
         end else if (hitSpare) begin
            rdData_d = RO_FILL;                                      // [R4]
         end else if (hitCtrl) begin
            rdData_d = ctrlRead;
         end else if (hitNormal) begin
            rdData_d = codeRead(span_q, normalCode_q);               // [R2] [R5]
         end else begin
            rdMiss_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rdData_q  <= '0;
         rdValid_q <= 1'b0;
         rdMiss_q  <= 1'b0;
      end else begin
         rdData_q  <= rdData_d;
         rdValid_q <= rdValid_d;
         rdMiss_q  <= rdMiss_d;
      end
   end

   assign regRdData  = rdData_q;
   assign regRdValid = rdValid_q;
   assign regRdMiss  = rdMiss_q;

   // -------------------------------------------------------------------------
   // Target selection and decode
   // -------------------------------------------------------------------------
   btcr_code_t selCode;
   btcr_mv_t   selMv;
   logic       selAdjust;

   always_comb begin
      selCode = bankPinSync ? standbyCode_q : normalCode_q;          // [R12]
   end

   btcr_vdecode u_decode (
      .spanHigh   (span_q),
      .code       (selCode),
      .millivolts (selMv),
      .adjustable (selAdjust)
   );

   // -------------------------------------------------------------------------
   // Enable and fault outputs
   // -------------------------------------------------------------------------
   logic       chanEn_q;
   logic       chanEn_d;
   logic       fault_q;
   logic       fault_d;

   // Both follow their pins three edges late: two synchroniser stages and this register
   always_comb begin
      chanEn_d = enablePinSync & enableBit_q;                        // [R10]
      fault_d  = faultSync & unmask_q;                               // [R3]
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         chanEn_q <= 1'b0;
         fault_q  <= 1'b0;
      end else begin
         chanEn_q <= chanEn_d;
         fault_q  <= fault_d;
      end
   end

   // -------------------------------------------------------------------------
   // Target outputs
   // -------------------------------------------------------------------------
   btcr_code_t actCode_q;
   btcr_code_t actCode_d;
   logic       spanOut_q;
   logic       spanOut_d;
   logic       adjust_q;
   logic       adjust_d;
   btcr_mv_t   target_q;
   btcr_mv_t   target_d;
   logic       changed_q;
   logic       changed_d;

   always_comb begin
      actCode_d = selCode;                                           // [R9] [R12]
      spanOut_d = span_q;                                            // [R5]
      adjust_d  = selAdjust;                                         // [R8]
      target_d  = selMv;                                             // [R7]
      // One-cycle pulse lets the converter restart its ramp on a new setting
      changed_d = (selMv != target_q) || (span_q != spanOut_q) || (selCode != actCode_q);
   end

   // Target resets to zero, so the first edge after reset loads it and pulses the change
   always_ff @(posedge clock) begin
      if (rst) begin
         actCode_q <= RST_NORMAL_CODE;
         spanOut_q <= RST_SPAN;
         adjust_q  <= 1'b0;
         target_q  <= '0;
         changed_q <= 1'b0;
      end else begin
         actCode_q <= actCode_d;
         spanOut_q <= spanOut_d;
         adjust_q  <= adjust_d;
         target_q  <= target_d;
         changed_q <= changed_d;
      end
   end

   assign channelEnable    = chanEn_q;
   assign activeCode       = actCode_q;
   assign spanHigh         = spanOut_q;
   assign adjustableMode   = adjust_q;
   assign targetMillivolts = target_q;
   assign targetChanged    = changed_q;
   assign voltageFault     = fault_q;
endmodule

// ---- verification/btcr_properties.sv ----
// Port-level assertions for the buck three register bank
`timescale 1ns/1ps
module btcr_properties (
   // Clock and reset
   input wire logic                 clock,
   input wire logic                 rst,
   // Register port
   input wire btcr_pkg::btcr_byte_t regAddr,
   input wire logic                 regRdEn,
   input wire btcr_pkg::btcr_byte_t regRdData,
   input wire logic                 regRdValid,
   input wire logic                 regRdMiss,
   // Pins
   input wire logic                 channelEnablePin,
   input wire logic                 voltageFaultIn,
   // Converter control
   input wire logic                 channelEnable,
   input wire btcr_pkg::btcr_code_t activeCode,
   input wire logic                 spanHigh,
   input wire logic                 adjustableMode,
   input wire btcr_pkg::btcr_mv_t   targetMillivolts,
   input wire logic                 voltageFault
);
   import btcr_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_rd_valid;
      regRdEn |=> regRdValid;
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
   property p_rd_quiet;
      !regRdEn |=> !regRdValid;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
   property p_miss;
      regRdMiss |-> regRdValid && regRdData == 8'h00;
   endproperty
   a_miss: assert property (p_miss) else $error("miss without zero data");
   property p_spare;
      regRdEn && regAddr == 8'h31 |=> regRdData == 8'h00 && !regRdMiss;
   endproperty
   a_spare: assert property (p_spare) else $error("spare read wrong");
   property p_enable;
      !channelEnablePin [*4] |-> !channelEnable;
   endproperty
   a_enable: assert property (p_enable) else $error("enabled with pin low");
   property p_fault;
      !voltageFaultIn [*4] |-> !voltageFault;
   endproperty
   a_fault: assert property (p_fault) else $error("fault without cause");
   property p_adj;
      adjustableMode |-> activeCode == 6'h00 && targetMillivolts == 13'h0000;
   endproperty
   a_adj: assert property (p_adj) else $error("adjustable mode wrong");
   // Target reads zero for a cycle after reset, so skip that cycle and wait until span is stable
   property p_low;
      !adjustableMode && !spanHigh && $stable(spanHigh) && !$past(rst) |->
         targetMillivolts == ((13'h271 + 13'h19 * activeCode) < 13'h320 ? 13'h320
                              : 13'h271 + 13'h19 * activeCode);
   endproperty
   a_low: assert property (p_low) else $error("low range decode wrong");
   property p_high;
      !adjustableMode && spanHigh && $stable(spanHigh) && !$past(rst) |->
         targetMillivolts == 13'h4e2 + 13'h32 * activeCode;
   endproperty
   a_high: assert property (p_high) else $error("high range decode wrong");
endmodule

bind btcr_top btcr_properties u_props (.clock, .rst, .regAddr, .regRdEn, .regRdData,
   .regRdValid, .regRdMiss, .channelEnablePin, .voltageFaultIn, .channelEnable,
   .activeCode, .spanHigh, .adjustableMode, .targetMillivolts, .voltageFault);

// ---- verification/btcr_host_model.sv ----
// Host side of the register port: byte writes and reads
`timescale 1ns/1ps
module btcr_host_model (
   // Clock
   input  wire logic                 clock,
   // Requests
   output btcr_pkg::btcr_byte_t      regAddr,
   output btcr_pkg::btcr_byte_t      regWrData,
   output logic                      regWrEn,
   output logic                      regRdEn,
   // Answers
   input  wire btcr_pkg::btcr_byte_t regRdData,
   input  wire logic                 regRdValid,
   input  wire logic                 regRdMiss
);
   import btcr_pkg::*;
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   // Released lines carry inverted data so stale values never look valid
   task automatic wr(input btcr_byte_t a, input btcr_byte_t d);
      @(negedge clock);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clock);
      regWrEn = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
   endtask
   task automatic rd(input btcr_byte_t a, output btcr_byte_t d, output logic v,
                     output logic m);
      @(negedge clock);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clock);
      regRdEn = 1'b0;
      regAddr = ~a;
      d = regRdData;
      v = regRdValid;
      m = regRdMiss;
   endtask
endmodule

// ---- verification/tb_buck_three_control_registers.sv ----
// Self-checking bench for the buck three register bank
`timescale 1ns/1ps
`define CHK(a,b) begin nTests++; if ((a) !== (b)) begin errors++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_buck_three_control_registers;
   import btcr_pkg::*;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   btcr_byte_t regAddr, regWrData, regRdData;
   logic       regWrEn, regRdEn, regRdValid, regRdMiss;
   logic       channelEnablePin = 1'b1;
   logic       voltageBankPin = 1'b0;
   logic       powerGoodIn = 1'b1;
   logic       voltageFaultIn = 1'b0;
   logic       channelEnable, spanHigh, adjustableMode, targetChanged, voltageFault;
   btcr_code_t activeCode;
   btcr_mv_t   targetMillivolts;
   int         errors = 0;
   int         nTests = 0;
   int         cycles = 0;
   always #2.5 clock = ~clock;
   btcr_host_model host (.clock, .regAddr, .regWrData, .regWrEn, .regRdEn,
      .regRdData, .regRdValid, .regRdMiss);
   btcr_top dut (.clock, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
      .regRdData, .regRdValid, .regRdMiss, .channelEnablePin, .voltageBankPin,
      .powerGoodIn, .voltageFaultIn, .channelEnable, .activeCode, .spanHigh,
      .adjustableMode, .targetMillivolts, .targetChanged, .voltageFault);
   // ------------------------------
   // Helpers
   // ------------------------------
   task automatic rdchk(input btcr_byte_t a, input btcr_byte_t e);
      btcr_byte_t d;
      logic v, m;
      host.rd(a, d, v, m);
      `CHK(v, 1'b1)
      `CHK(m, 1'b0)
      `CHK(d, e)
   endtask
   // Pin paths need three edges; four cycles leave margin
   task automatic settle();
      repeat (4) @(negedge clock);
   endtask
   // Every call moves the setting, so the change pulse shows for exactly one cycle
   task automatic tgt(input logic s, input btcr_code_t c, input btcr_mv_t mv);
      host.wr(8'h33, {1'b0, s, c});
      @(negedge clock);
      `CHK(targetChanged, 1'b1)
      @(negedge clock);
      `CHK(targetChanged, 1'b0)
      settle();
      `CHK(activeCode, c)
      `CHK(spanHigh, s)
      `CHK(adjustableMode, c == 6'h00)
      `CHK(targetMillivolts, mv)
   endtask
   task final_report();
      $display("comparisons %0d mismatches %0d", nTests, errors);
      if (errors == 0 && nTests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_defaults();
      rdchk(8'h30, 8'h18);
      rdchk(8'h31, 8'h00);
      rdchk(8'h32, 8'h06);
      rdchk(8'h33, 8'h18);
      `CHK(targetMillivolts, 13'h4c9)
      voltageBankPin = 1'b1;
      settle();
      `CHK(targetMillivolts, 13'h4c9)
      voltageBankPin = 1'b0;
      settle();
      $display("test defaults done");
   endtask
   task automatic t_access();
      btcr_byte_t d;
      logic v, m;
      host.wr(8'h30, 8'hff);
      rdchk(8'h30, 8'h3f);
      host.wr(8'h31, 8'haa);
      rdchk(8'h31, 8'h00);
      host.wr(8'h32, 8'hff);
      rdchk(8'h32, 8'h07);
      // Span stays low: 2.2V is inside the span already selected
      host.wr(8'h33, 8'hbf);
      rdchk(8'h33, 8'h3f);
      host.rd(8'h40, d, v, m);
      `CHK({v, m, d}, 10'h300)
      host.wr(8'h32, 8'h04);
      $display("test access done");
   endtask
   task automatic t_decode();
      tgt(1'b0, 6'h00, 13'h0000);
      tgt(1'b0, 6'h01, 13'h0320);
      tgt(1'b0, 6'h07, 13'h0320);
      tgt(1'b0, 6'h08, 13'h0339);
      tgt(1'b0, 6'h3f, 13'h0898);
      // Target 1.3V lies inside both spans before the span moves
      tgt(1'b1, 6'h01, 13'h0514);
      tgt(1'b1, 6'h3f, 13'h1130);
      tgt(1'b1, 6'h00, 13'h0000);
      $display("test decode done");
   endtask
   task automatic t_bank();
      tgt(1'b0, 6'h3f, 13'h0898);
      host.wr(8'h30, 8'h10);
      voltageBankPin = 1'b1;
      settle();
      `CHK(activeCode, 6'h10)
      `CHK(targetMillivolts, 13'h0401)
      voltageBankPin = 1'b0;
      settle();
      `CHK(targetMillivolts, 13'h0898)
      $display("test bank done");
   endtask
   task automatic t_status();
      settle();
      `CHK(channelEnable, 1'b0)
      host.wr(8'h32, 8'h05);
      settle();
      `CHK(channelEnable, 1'b1)
      channelEnablePin = 1'b0;
      powerGoodIn = 1'b0;
      voltageFaultIn = 1'b1;
      settle();
      `CHK(channelEnable, 1'b0)
      `CHK(voltageFault, 1'b1)
      rdchk(8'h32, 8'h05);
      host.wr(8'h32, 8'h01);
      settle();
      `CHK(voltageFault, 1'b0)
      channelEnablePin = 1'b1;
      powerGoodIn = 1'b1;
      voltageFaultIn = 1'b0;
      $display("test status done");
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(negedge clock);
      rst = 1'b0;
      repeat (3) @(negedge clock);
      t_defaults();
      t_access();
      t_decode();
      t_bank();
      t_status();
      final_report();
   end
endmodule
